/* File: common/nbcs_pkg.sv */
/*
  Constants for the nibble core sequencing and addressing state.
  Assumes a 32-bit APB master and a 100 MHz core clock.
*/
package nbcs_pkg;
  // ==========================================================
  // Widths
  localparam int PC_W     = 15;  // Fetch address width
  localparam int SP_W     = 8;   // Stack pointer width
  localparam int BSC_W    = 16;  // Bit carrier width
  localparam int DADDR_W  = 12;  // Data address width
  // ==========================================================
  // APB offsets (byte addresses)
  localparam logic [7:0] OFS_PC    = 8'h00;
  localparam logic [7:0] OFS_SP    = 8'h04;
  localparam logic [7:0] OFS_PSW   = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_CARRY = 8'h10;
  localparam logic [7:0] OFS_BANK  = 8'h14;
  localparam logic [7:0] OFS_BSC   = 8'h18;
  localparam logic [7:0] OFS_LPTR  = 8'h1C;
  localparam logic [7:0] OFS_BIT   = 8'h20;
  // ==========================================================
  // Status word field positions
  localparam int PSW_IS_HI = 7;
  localparam int PSW_IS_LO = 6;
  localparam int PSW_EMB   = 5;
  localparam int PSW_ERB   = 4;
  localparam int PSW_C     = 3;
  // ==========================================================
  // Reset values
  localparam logic [14:0] RST_PC  = 15'h0000;
  localparam logic [7:0]  RST_SP  = 8'h00;
  localparam logic [7:0]  RST_PSW = 8'h00;
  // ==========================================================
  // Program memory regions
  localparam logic [14:0] TABLE_BASE = 15'h0020;
  localparam logic [14:0] TABLE_LAST = 15'h007F;
  localparam int          TABLE_ENT  = 48;
  // ==========================================================
  // Stack frame lengths in nibbles
  localparam logic [2:0] CTX_NIB = 3'h6;
  localparam logic [2:0] SB_NIB  = 3'h2;
  // Banks with special contents
  localparam logic [3:0] BANK_LCD = 4'hE;
  localparam logic [3:0] BANK_IO  = 4'hF;
  // Execution cycles for narrow and wide operations
  localparam logic [1:0] CYC_NARROW = 2'h1;
  localparam logic [1:0] CYC_WIDE   = 2'h2;
  // Stack sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_POP  = 2'b10,
    ST_FIN  = 2'b11
  } nbcs_state_t;
endpackage : nbcs_pkg

/* File: src/nbcs_core_state.sv */
/*
  Fetch address, stack sequencer, bank selects, status word,
  bit carrier and data address mapping for a nibble core.
  Assumes the instruction logic on the same clock issues
  one-cycle requests and that stack RAM read data is valid
  the cycle after a read strobe.
*/
// Local design decisions: the APB slave port and the register offsets.
// Operation
// R1: Advance fetch address by fetched length
// R2: Table call fetch keeps address unchanged
// R3: Reset or interrupt loads vector bits
// R4: Stack pointer bit zero always zero
// R5: Calls save and restore context frame
// R6: Stack always reaches bank zero area
// R7: Software initialises stack pointer to zero
// R8: Wide address space; wide ops two cycles
// R9: Vector region then small general region
// R10: Table entries lie in 0020H..007FH
// R11: Short jump form executes from table
// R12: Sixteen data banks, selectable
// R13: Bank sizes and special banks mapped
// R14: Bank enable low limits reachable area
// R15: Software initialises data memory itself
// R16: Four register banks of eight nibbles
// R17: Accumulator and pointer pairs addressable
// R18: Software keeps register bank usage split
// R19: Bit carrier direct and indexed access
// R20: Status word layout, saved on interrupt
// R21: Status word reachable regardless of flags
// R22: Status fields access widths enforced
// R23: Bank select values stored
// R24: Bank selects pushed and popped together
// R25: Register bank applied only when enabled
`timescale 1ns/1ps
module nbcs_core_state #(
  parameter int TABLE_ENTRIES = nbcs_pkg::TABLE_ENT
) (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_clock_en,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_fetch,
  input  wire logic [1:0]  i_fetch_len,
  input  wire logic        i_fetch_ref,
  input  wire logic [5:0]  i_ref_index,
  input  wire logic        i_vector_load,
  input  wire logic [13:0] i_vector_addr,
  input  wire logic        i_short_jump,
  input  wire logic [11:0] i_short_target,
  input  wire logic        i_push_ctx,
  input  wire logic        i_pop_ctx,
  input  wire logic        i_push_sb,
  input  wire logic        i_pop_sb,
  input  wire logic [3:0]  i_stack_rdata,
  input  wire logic        i_flag_we,
  input  wire logic        i_carry,
  input  wire logic [2:0]  i_skip,
  input  wire logic        i_smb_we,
  input  wire logic [3:0]  i_smb,
  input  wire logic        i_srb_we,
  input  wire logic [1:0]  i_srb,
  input  wire logic [7:0]  i_data_addr,
  input  wire logic [2:0]  i_reg_num,
  input  wire logic        i_reg_pair,
  input  wire logic        i_op_wide,
  output logic      [14:0] o_program_counter,
  output logic      [14:0] o_table_addr,
  output logic             o_table_err,
  output logic             o_stack_we,
  output logic             o_stack_re,
  output logic      [11:0] o_stack_addr,
  output logic      [3:0]  o_stack_wdata,
  output logic             o_stack_busy,
  output logic      [11:0] o_data_phys,
  output logic             o_data_ok,
  output logic             o_data_five,
  output logic      [7:0]  o_reg_phys,
  output logic      [1:0]  o_exec_cycles
);
  // ==========================================================
  // Elaboration check
  if (TABLE_ENTRIES < 1 || TABLE_ENTRIES > nbcs_pkg::TABLE_ENT)
  begin : g_bad_table
    $error("TABLE_ENTRIES out of range");
  end

  // ==========================================================
  // State
  logic [14:0]             program_counter;  // Fetch address
  logic [7:0]              stack_pointer;    // Bit 0 held zero
  logic [7:0]              program_status_word;
  logic [3:0]              memory_bank_select;
  logic [1:0]              register_bank_select;
  logic [15:0]             bit_sequence_carrier;
  logic [3:0]              low_ptr;          // Bit index
  nbcs_pkg::nbcs_state_t   state;            // Stack sequencer
  logic [2:0]              nib_cnt;          // Nibbles left
  logic [7:0]              ptr;              // Walking address
  logic [23:0]             frame;            // Saved context
  logic                    pop_is_ctx;       // Frame kind
  logic                    rd_pend;          // Read data due

  // ==========================================================
  // APB decode
  logic acc;    // Access phase sampled
  logic wr_en;  // Write takes effect now
  assign acc   = i_psel && i_penable;
  assign wr_en = acc && o_pready && i_pwrite;

  // Address hit test
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= nbcs_pkg::OFS_BIT) && (a[1:0] == 2'b00);
  endfunction : is_mapped

  // Read value; status word visible whatever the flags hold
  function automatic logic [31:0] rd_val(input logic [7:0] a);
    rd_val = 32'h0000_0000;
    unique case (a)
      nbcs_pkg::OFS_PC:    rd_val[14:0] = program_counter;
      nbcs_pkg::OFS_SP:    rd_val[7:0]  = stack_pointer;
      // R21: no enable gating on read
      nbcs_pkg::OFS_PSW:   rd_val[7:0]  = program_status_word;
      nbcs_pkg::OFS_FLAGS: rd_val[3:0]  = program_status_word[7:4];
      nbcs_pkg::OFS_CARRY: rd_val[0]    =
        program_status_word[nbcs_pkg::PSW_C];
      nbcs_pkg::OFS_BANK:  rd_val[5:0]  =
        {register_bank_select, memory_bank_select};
      nbcs_pkg::OFS_BSC:   rd_val[15:0] = bit_sequence_carrier;
      nbcs_pkg::OFS_LPTR:  rd_val[3:0]  = low_ptr;
      nbcs_pkg::OFS_BIT:   rd_val[0]    = bit_sequence_carrier[low_ptr];
      default:             rd_val       = 32'h0000_0000;
    endcase
  endfunction : rd_val

  // ==========================================================
  // Bus answer: one wait state, data and error from flops
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (i_clock_en)
    begin
      o_pready  <= acc && !o_pready;
      o_prdata  <= rd_val(i_paddr);
      o_pslverr <= acc && !o_pready && !is_mapped(i_paddr);
    end
  end

  // ==========================================================
  // Fetch address sequencing
  logic ctx_done;  // Context frame fully read back
  logic sb_done;   // Bank frame fully read back
  assign ctx_done = (state == nbcs_pkg::ST_FIN) && !rd_pend
                    && !o_stack_re && pop_is_ctx;
  assign sb_done  = (state == nbcs_pkg::ST_FIN) && !rd_pend
                    && !o_stack_re && !pop_is_ctx;

  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
      program_counter <= nbcs_pkg::RST_PC;
    else if (i_clock_en)
    begin
      // R3: vector load
      if (i_vector_load)
        program_counter <= {1'b0, i_vector_addr};
      // R5: return address restored
      else if (ctx_done)
        program_counter <= frame[22:8];
      // R11: short form jump in page
      else if (i_short_jump)
        program_counter <= {program_counter[14:12], i_short_target};
      // R1: step by instruction length
      else if (i_fetch && !i_fetch_ref)
        program_counter <= program_counter + {13'h0000, i_fetch_len};
      // R2: table call holds address
      else
        program_counter <= program_counter;
    end
  end
  assign o_program_counter = program_counter;

  // ==========================================================
  // Table slot address; entries are two bytes
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      o_table_addr <= nbcs_pkg::TABLE_BASE;
      o_table_err  <= 1'b0;
    end
    else if (i_clock_en && i_fetch && i_fetch_ref)
    begin
      // R9: table sits above first 32 bytes
      // R10: slot inside reference area
      o_table_addr <= nbcs_pkg::TABLE_BASE + {8'h00, i_ref_index, 1'b0};
      o_table_err  <= 32'(i_ref_index) >= TABLE_ENTRIES;
    end
  end

  // ==========================================================
  // Nibble picker for pushes
  function automatic logic [3:0] nib(input logic [23:0] f,
                                     input logic [2:0]  i);
    nib = 4'(f >> {i, 2'b00});
  endfunction : nib

  // ==========================================================
  // Stack sequencer; owns the stack pointer
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      state         <= nbcs_pkg::ST_IDLE;
      stack_pointer <= nbcs_pkg::RST_SP;
      nib_cnt       <= 3'h0;
      ptr           <= 8'h00;
      pop_is_ctx    <= 1'b0;
      o_stack_we    <= 1'b0;
      o_stack_re    <= 1'b0;
      o_stack_addr  <= 12'h000;
      o_stack_wdata <= 4'h0;
    end
    else if (i_clock_en)
    begin
      unique case (state)
        nbcs_pkg::ST_IDLE:
        begin
          ptr <= stack_pointer;
          // R5: context save and restore
          if (i_push_ctx || i_pop_ctx)
          begin
            nib_cnt <= nbcs_pkg::CTX_NIB;
            state   <= i_push_ctx ? nbcs_pkg::ST_PUSH : nbcs_pkg::ST_POP;
          end
          // R24: bank selects together
          else if (i_push_sb || i_pop_sb)
          begin
            nib_cnt <= nbcs_pkg::SB_NIB;
            state   <= i_push_sb ? nbcs_pkg::ST_PUSH : nbcs_pkg::ST_POP;
          end
          // R4: low bit forced clear
          else if (wr_en && i_paddr == nbcs_pkg::OFS_SP)
            stack_pointer <= {i_pwdata[7:1], 1'b0};
          pop_is_ctx <= i_pop_ctx;
        end
        nbcs_pkg::ST_PUSH:
        begin
          if (nib_cnt != 3'h0)
          begin
            // R6: bank 0 whatever the flags
            o_stack_we    <= 1'b1;
            o_stack_addr  <= {4'h0, 8'(ptr - 8'h01)};
            o_stack_wdata <= nib(frame, 3'(nib_cnt - 3'h1));
            ptr           <= 8'(ptr - 8'h01);
            nib_cnt       <= 3'(nib_cnt - 3'h1);
          end
          else
          begin
            o_stack_we    <= 1'b0;
            stack_pointer <= ptr;
            state         <= nbcs_pkg::ST_IDLE;
          end
        end
        nbcs_pkg::ST_POP:
        begin
          if (nib_cnt != 3'h0)
          begin
            o_stack_re   <= 1'b1;
            o_stack_addr <= {4'h0, ptr};
            ptr          <= 8'(ptr + 8'h01);
            nib_cnt      <= 3'(nib_cnt - 3'h1);
          end
          else
          begin
            o_stack_re <= 1'b0;
            state      <= nbcs_pkg::ST_FIN;
          end
        end
        nbcs_pkg::ST_FIN:
        begin
          // Wait for the last nibble before committing
          if (!rd_pend && !o_stack_re)
          begin
            stack_pointer <= ptr;
            state         <= nbcs_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end
  // Busy flag kept as a flop for a clean output
  logic busy_q;
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
      busy_q <= 1'b0;
    else if (i_clock_en)
      busy_q <= (state != nbcs_pkg::ST_IDLE) || i_push_ctx
                || i_pop_ctx || i_push_sb || i_pop_sb;
  end
  assign o_stack_busy = busy_q;

  // ==========================================================
  // Frame capture on push, shift in on pop (least first)
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      frame   <= 24'h00_0000;
      rd_pend <= 1'b0;
    end
    else if (i_clock_en)
    begin
      rd_pend <= o_stack_re;
      // R20: status word saved with return address
      if (state == nbcs_pkg::ST_IDLE && i_push_ctx)
        frame <= {1'b0, program_counter, program_status_word};
      else if (state == nbcs_pkg::ST_IDLE && i_push_sb)
        frame <= {16'h0000, memory_bank_select, 2'b00,
                  register_bank_select};
      else if (rd_pend)
        frame <= {i_stack_rdata, frame[23:4]};
    end
  end

  // ==========================================================
  // Status word: hardware writes win over software
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
      program_status_word <= nbcs_pkg::RST_PSW;
    else if (i_clock_en)
    begin
      // R20: whole word restored after service
      if (ctx_done)
        program_status_word <= frame[7:0];
      else if (i_flag_we)
        program_status_word[3:0] <= {i_carry, i_skip};
      // R22: nibble and bit writes only
      else if (wr_en && i_paddr == nbcs_pkg::OFS_FLAGS)
        program_status_word[7:4] <= i_pwdata[3:0];
      else if (wr_en && i_paddr == nbcs_pkg::OFS_CARRY)
        program_status_word[nbcs_pkg::PSW_C] <= i_pwdata[0];
    end
  end

  // ==========================================================
  // Bank selects
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      memory_bank_select   <= 4'h0;
      register_bank_select <= 2'h0;
    end
    else if (i_clock_en)
    begin
      // R24: restored as a pair
      if (sb_done)
      begin
        memory_bank_select   <= frame[23:20];
        register_bank_select <= frame[17:16];
      end
      else
      begin
        // R23: bank numbers stored
        if (i_smb_we)
          memory_bank_select <= i_smb;
        else if (wr_en && i_paddr == nbcs_pkg::OFS_BANK)
          memory_bank_select <= i_pwdata[3:0];
        if (i_srb_we)
          register_bank_select <= i_srb;
        else if (wr_en && i_paddr == nbcs_pkg::OFS_BANK)
          register_bank_select <= i_pwdata[5:4];
      end
    end
  end

  // ==========================================================
  // Bit carrier: direct word or bit by low pointer
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      bit_sequence_carrier <= 16'h0000;
      low_ptr              <= 4'h0;
    end
    else if (i_clock_en && wr_en)
    begin
      // R19: direct and indexed access
      if (i_paddr == nbcs_pkg::OFS_BSC)
        bit_sequence_carrier <= i_pwdata[15:0];
      else if (i_paddr == nbcs_pkg::OFS_LPTR)
        low_ptr <= i_pwdata[3:0];
      else if (i_paddr == nbcs_pkg::OFS_BIT)
      begin
        bit_sequence_carrier[low_ptr] <= i_pwdata[0];
        // Step the index to walk a serial pattern
        if (i_pwdata[1])
          low_ptr <= 4'(low_ptr + 4'h1);
        else if (i_pwdata[2])
          low_ptr <= 4'(low_ptr - 4'h1);
      end
    end
  end

  // ==========================================================
  // Data and working register address mapping
  logic       memory_bank_enable_flag;   // Memory bank enable
  logic       register_bank_enable_flag;   // Register bank enable
  logic [3:0] bank;  // Effective data bank
  assign memory_bank_enable_flag  = program_status_word[nbcs_pkg::PSW_EMB];
  assign register_bank_enable_flag  = program_status_word[nbcs_pkg::PSW_ERB];
  // R14: low half bank 0, high half I/O
  assign bank = memory_bank_enable_flag ? memory_bank_select
                    : (i_data_addr[7] ? nbcs_pkg::BANK_IO : 4'h0);

  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      o_data_phys   <= 12'h000;
      o_data_ok     <= 1'b0;
      o_data_five   <= 1'b0;
      o_reg_phys    <= 8'h00;
      o_exec_cycles <= nbcs_pkg::CYC_NARROW;
    end
    else if (i_clock_en)
    begin
      // R12: bank forms top nibble
      o_data_phys <= {bank, i_data_addr};
      // R13: I/O bank holds upper half only
      o_data_ok   <= !(bank == nbcs_pkg::BANK_IO && !i_data_addr[7]);
      o_data_five <= bank == nbcs_pkg::BANK_LCD;
      // R25: bank 0 unless enabled
      // R16: pairs start on even register
      // R17: accumulator and pointers are numbers
      o_reg_phys  <= {3'b000, register_bank_enable_flag ? register_bank_select : 2'b00,
                      i_reg_num[2:1], i_reg_num[0] && !i_reg_pair};
      // R8: wide operations take two
      o_exec_cycles <= i_op_wide ? nbcs_pkg::CYC_WIDE
                                 : nbcs_pkg::CYC_NARROW;
    end
  end

  // ==========================================================
  // Checks
  // R4: stack pointer even
  sp_even_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !stack_pointer[0]) else $error("stack pointer odd");
  // R2: table fetch holds address
  ref_hold_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_clock_en && i_fetch && i_fetch_ref && !i_vector_load
    && !ctx_done && !i_short_jump |=> $stable(program_counter))
    else $error("table call moved address");
  // R1: step equals length
  fetch_step_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_clock_en && i_fetch && !i_fetch_ref && !i_vector_load
    && !ctx_done && !i_short_jump
    |=> program_counter == 15'($past(program_counter) + $past(i_fetch_len)))
    else $error("fetch step wrong");
  // R3: vector loaded
  vector_load_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_clock_en && i_vector_load
    |=> program_counter == {1'b0, $past(i_vector_addr)})
    else $error("vector not loaded");
  // R6: stack writes stay in bank 0
  stack_bank_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    o_stack_we || o_stack_re |-> o_stack_addr[11:8] == 4'h0)
    else $error("stack left bank 0");
  // R5: six writes in a row for a context push
  ctx_push_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    state == nbcs_pkg::ST_IDLE && i_push_ctx && i_clock_en
    ##1 i_clock_en |=> o_stack_we [*6] ##1 !o_stack_we)
    else $error("context push length wrong");
  // R14: enable low blocks lower I/O half
  emb_gate_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_clock_en && !memory_bank_enable_flag
    |=> o_data_ok && (o_data_phys[11:8] == 4'h0
                      || o_data_phys[11:8] == 4'hF))
    else $error("bank gating wrong");
  // R22: skip bits untouched by bus writes
  skip_ro_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_clock_en && wr_en && !i_flag_we && !ctx_done
    |=> program_status_word[2:0] == $past(program_status_word[2:0]))
    else $error("skip bits written by bus");
  // R25: register bank only when enabled
  reg_bank_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_clock_en && !register_bank_enable_flag |=> o_reg_phys[4:3] == 2'b00)
    else $error("register bank leaked");
  // R10: table slot inside area
  table_range_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !o_table_err |-> o_table_addr <= nbcs_pkg::TABLE_LAST)
    else $error("table slot out of area");
endmodule : nbcs_core_state

/* File: bench/tb.sv */
/*
  Self-checking bench for nbcs_core_state: APB registers, fetch address,
  context push, data and register mapping, bit carrier window.
  Assumes nbcs_pkg is compiled first; clock 100 MHz, sync active-low reset.
*/
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Stimulus and observed signals
  logic i_clock, i_nrst, i_clock_en, i_psel, i_penable, i_pwrite, i_fetch, i_fetch_ref;
  logic i_vector_load, i_short_jump, i_push_ctx, i_pop_ctx, i_push_sb, i_pop_sb, i_flag_we;
  logic i_carry, i_smb_we, i_srb_we, i_reg_pair, i_op_wide, o_pready, o_pslverr;
  logic o_table_err, o_stack_we, o_stack_re, o_stack_busy, o_data_ok, o_data_five;
  logic [7:0]  i_paddr, i_data_addr, o_reg_phys;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [1:0]  i_fetch_len, i_srb, o_exec_cycles;
  logic [5:0]  i_ref_index;
  logic [13:0] i_vector_addr;
  logic [11:0] i_short_target, o_stack_addr, o_data_phys;
  logic [3:0]  i_stack_rdata, i_smb, o_stack_wdata;
  logic [2:0]  i_skip, i_reg_num;
  logic [14:0] o_program_counter, o_table_addr, pc;
  logic [23:0] frame;
  logic        er, r;
  int          num_errors, check_count, cyc, seed, k, len, idx;

  nbcs_core_state nbcs_core_state_i (.i_clock, .i_nrst, .i_clock_en, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_fetch, .i_fetch_len,
    .i_fetch_ref, .i_ref_index, .i_vector_load, .i_vector_addr, .i_short_jump,
    .i_short_target, .i_push_ctx, .i_pop_ctx, .i_push_sb, .i_pop_sb, .i_stack_rdata,
    .i_flag_we, .i_carry, .i_skip, .i_smb_we, .i_smb, .i_srb_we, .i_srb, .i_data_addr,
    .i_reg_num, .i_reg_pair, .i_op_wide, .o_program_counter, .o_table_addr, .o_table_err,
    .o_stack_we, .o_stack_re, .o_stack_addr, .o_stack_wdata, .o_stack_busy, .o_data_phys,
    .o_data_ok, .o_data_five, .o_reg_phys, .o_exec_cycles);

  // ==========================================================
  // Clock and hang guard; ceiling far above the few hundred cycles used
  initial
  begin
    i_clock = 0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; ready, data and error taken at one rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge i_clock);
    i_penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
  endtask : apb

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Main sequence
  initial
  begin
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_fetch, i_fetch_len, i_fetch_ref} = '0;
    {i_ref_index, i_vector_load, i_vector_addr, i_short_jump, i_short_target, i_push_ctx} = '0;
    {i_pop_ctx, i_push_sb, i_pop_sb, i_stack_rdata, i_flag_we, i_carry, i_skip} = '0;
    {i_smb_we, i_smb, i_srb_we, i_srb, i_data_addr, i_reg_num, i_reg_pair, i_op_wide} = '0;
    {num_errors, check_count, cyc, i_nrst} = '0;
    i_clock_en = 1'b1;
    seed = 32'h9e8b;
    pc = 15'h0000;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    // Fetch advance, table call and its slot address; slots 47 and 48 forced
    for (k = 0; k < 30; k++)
    begin
      len = ($random(seed) & 3) % 3 + 1;
      r = $random(seed);
      idx = (k == 1) ? 47 : (k == 2) ? 48 : ($random(seed) & 63);
      @(posedge i_clock);
      {i_fetch, i_fetch_len, i_fetch_ref, i_ref_index} <= {1'b1, 2'(len), r, 6'(idx)};
      @(posedge i_clock);
      i_fetch <= 1'b0;
      if (!r) pc = pc + 15'(len);
      @(negedge i_clock);
      chk(o_program_counter, pc);
      if (r) chk(o_table_addr, 32'h0020 + 2 * idx);
      if (r) chk(o_table_err, idx >= nbcs_pkg::TABLE_ENT);
    end
    // Vector load then short jump keeps the top bits
    @(posedge i_clock);
    {i_vector_load, i_vector_addr} <= {1'b1, 14'h3a5c};
    @(posedge i_clock);
    {i_vector_load, i_short_jump, i_short_target} <= {1'b0, 1'b1, 12'h0456};
    @(negedge i_clock);
    chk(o_program_counter, 15'h3a5c);
    @(posedge i_clock);
    i_short_jump <= 1'b0;
    @(negedge i_clock);
    chk(o_program_counter, 15'h3456);
    pc = 15'h3456;
    // Stack pointer bit zero stays clear
    apb(1'b1, nbcs_pkg::OFS_SP, 32'h0000_00a5);
    apb(1'b0, nbcs_pkg::OFS_SP, 32'h0000_0000);
    chk(rd, 32'h0000_00a4);
    apb(1'b1, nbcs_pkg::OFS_SP, 32'h0000_0000);
    // Status word: flags by APB, carry and skip by core, 8-bit view read only
    apb(1'b1, nbcs_pkg::OFS_FLAGS, 32'h0000_000a);
    @(posedge i_clock);
    {i_flag_we, i_carry, i_skip} <= {1'b1, 1'b1, 3'h5};
    @(posedge i_clock);
    i_flag_we <= 1'b0;
    apb(1'b1, nbcs_pkg::OFS_PSW, 32'h0000_00ff);
    apb(1'b0, nbcs_pkg::OFS_PSW, 32'h0000_0000);
    chk(rd, 32'h0000_00ad);
    apb(1'b1, nbcs_pkg::OFS_BANK, 32'h0000_0025);
    // Context push lands in bank 0 from 0FFH downward, high nibble first
    @(posedge i_clock);
    i_push_ctx <= 1'b1;
    @(posedge i_clock);
    i_push_ctx <= 1'b0;
    frame = {1'b0, pc, 8'had};
    k = 0;
    repeat (14)
    begin
      @(negedge i_clock);
      if (o_stack_we === 1'b1) chk(o_stack_addr, 12'h0ff - 12'(k));
      if (o_stack_we === 1'b1) chk(o_stack_wdata, frame[23 - 4 * k -: 4]);
      if (o_stack_we === 1'b1) chk(o_stack_busy, 1'b1);
      if (o_stack_we === 1'b1) k++;
    end
    chk(k, 6);
    chk(o_stack_busy, 1'b0);
    apb(1'b0, nbcs_pkg::OFS_SP, 32'h0000_0000);
    chk(rd, 32'h0000_00fa);
    // Context pop; each nibble fed the cycle after its read
    frame = {1'b0, 15'h2b71, 8'had};
    @(posedge i_clock);
    i_pop_ctx <= 1'b1;
    @(posedge i_clock);
    i_pop_ctx <= 1'b0;
    @(posedge i_clock);
    for (k = 0; k < 6; k++)
    begin
      @(negedge i_clock);
      chk(o_stack_re && o_stack_addr == 12'h0fa + 12'(k), 1'b1);
      @(posedge i_clock);
      i_stack_rdata <= frame[4 * k +: 4];
    end
    repeat (3) @(negedge i_clock);
    chk(o_program_counter, 15'h2b71);
    // Data and register mapping with memory bank enable set and register bank enable clear, then swapped
    @(posedge i_clock);
    {i_data_addr, i_reg_num, i_reg_pair, i_op_wide} <= {8'h12, 3'h5, 1'b0, 1'b1};
    @(posedge i_clock);
    @(negedge i_clock);
    chk(o_data_phys, 12'h512);
    chk(o_data_five, 1'b0);
    chk(o_reg_phys, 8'h05);
    chk(o_exec_cycles, 2'h2);
    apb(1'b1, nbcs_pkg::OFS_FLAGS, 32'h0000_0009);
    @(posedge i_clock);
    i_data_addr <= 8'h90;
    @(posedge i_clock);
    @(negedge i_clock);
    chk(o_data_phys, 12'hf90);
    chk(o_data_ok, 1'b1);
    chk(o_reg_phys, 8'h15);
    // Carrier: random word, then indexed bit write with increment
    idx = $random(seed);
    apb(1'b1, nbcs_pkg::OFS_BSC, 32'(idx));
    apb(1'b0, nbcs_pkg::OFS_BSC, 32'h0000_0000);
    chk(rd, {16'h0000, 16'(idx)});
    apb(1'b1, nbcs_pkg::OFS_BSC, 32'h0000_0000);
    apb(1'b1, nbcs_pkg::OFS_LPTR, 32'h0000_0003);
    apb(1'b1, nbcs_pkg::OFS_BIT, 32'h0000_0003);
    apb(1'b0, nbcs_pkg::OFS_BSC, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    apb(1'b0, nbcs_pkg::OFS_LPTR, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    // Unmapped address is refused
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk(er, 1'b1);
    wrap_up();
  end
endmodule : tb
